// >>> hdl/mcr_regs.sv
// Configuration and diagnostic register bank of the motor controller.
// Assumes a serial front end on the same clock giving register number, strobes and data,
// fault inputs from logic on the same clock, and an NVM engine with a request/done pair.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Dead time compensation gain equals the 4-bit gain field, 0 to 15.
// - Compensation ratio limit is ratio field times 6.25 percent of dead time.
// - Source select bit: 0 analog speed input, 1 register settings; default 1.
// - A 4-bit user tag is stored and read back with no control effect.
// - Speed unit equals one plus scale field, in tenths of a hertz.
// - Internal mode: reference frequency is target code times speed unit.
// - External mode: shared speed field gives maximum reference frequency.
// - Minimum reference frequency is minimum code times speed unit.
// - Full speed point is code over 174 volts; reset code 0x366.
// - Excitation starts at start code over 174 volts; reset code 0x1b3.
// - Minimum speed point is code over 174 volts; reset code 0x15c.
// - Low power mode entered at sleep code over 174 volts; reset 0xae.
// - Store trigger one-to-zero while stopped and unlocked starts an NVM store.
// - A 10-bit write counter reads back and increments after each store.
// - Write count passing 1023 permanently sets the wear-limit flag.
// - A set mask bit disables its fault; default zero keeps it enabled.
// - Five-bit select, split over two registers, routes a signal to the fault pin.
// - Fault pin goes low while the selected condition is present.
// - Diagnostic read returns one per fault: critical flags high, maskable below.
// - Compensation enable bit gates the gain and ratio fields.
// - Every read returns the six critical flags above ten bits of the addressed register.
module mcr_regs
  import mcr_pkg::*;
#(
  parameter int unsigned CNT_W = 10
) (
  input  wire logic                        clock_i,
  input  wire logic                        reset_n_i,
  input  wire logic                        ce_i,
  input  wire logic [mcr_pkg::ADDR_W-1:0]  reg_addr_i,
  input  wire logic                        reg_wr_i,
  input  wire logic                        reg_rd_i,
  input  wire logic [mcr_pkg::DATA_W-1:0]  reg_wdata_i,
  output logic      [mcr_pkg::DATA_W-1:0]  reg_rdata_o,
  input  wire logic [mcr_pkg::NUM_MASKABLE-1:0] fault_raw_i,
  input  wire logic                        supply_undervolt_i,
  input  wire logic                        nvm_corrupt_i,
  input  wire logic                        timeout_fault_i,
  input  wire logic                        soft_overcurrent_i,
  input  wire logic [mcr_pkg::NUM_GATES-1:0] pwm_gate_i,
  input  wire logic                        motor_stopped_i,
  input  wire logic                        unlocked_i,
  input  wire logic                        nvm_store_done_i,
  input  wire logic [mcr_pkg::CODE_W-1:0]  speed_cmd_voltage_i,
  output logic                             nvm_store_req_o,
  output logic                             fault_out_pin_o,
  output logic                             dead_time_comp_en_o,
  output logic      [3:0]                  dead_time_comp_gain_o,
  output logic      [3:0]                  dead_time_max_ratio_o,
  output logic                             speed_source_sel_o,
  output logic      [4:0]                  freq_step_o,
  output logic      [14:0]                 ref_freq_o,
  output logic      [14:0]                 max_ref_freq_o,
  output logic      [14:0]                 min_ref_freq_o,
  output logic                             at_full_speed_o,
  output logic                             excite_on_o,
  output logic                             at_min_speed_o,
  output logic                             sleep_mode_o
);
  import mcr_pkg::*;

  if (CNT_W != 10) begin : g_bad_cnt
    $error("mcr_regs: write counter must be 10 bits");
  end

  // Stored settings
  logic        dtc_en_q;
  logic [3:0]  gain_q;
  logic [3:0]  ratio_q;
  logic        src_sel_q;
  logic [3:0]  user_tag_q;
  logic [3:0]  scale_q;
  logic [9:0]  speed_code_q;
  logic [9:0]  min_code_q;
  logic [9:0]  full_volt_q;
  logic [9:0]  start_volt_q;
  logic [9:0]  low_volt_q;
  logic [9:0]  sleep_volt_q;
  logic        trigger_q;
  logic [6:0]  mask_q;
  logic [2:0]  sel_hi_q;
  logic [1:0]  sel_lo_q;
  logic [CNT_W-1:0] count_q;
  logic        wear_q;
  logic [6:0]  fault_out_pin_q;
  logic [3:0]  crit_q;
  mcr_store_state_t state_q;

  // Decode
  wire wr_w = ce_i & reg_wr_i;
  wire wr_dt_w = wr_w & (reg_addr_i == REG_DEAD_TIME_CFG);
  wire wr_sl_w = wr_w & (reg_addr_i == REG_SPEED_LIMIT_CFG);
  wire wr_sr_w = wr_w & (reg_addr_i == REG_SPEED_REFERENCE_CFG);
  wire wr_mn_w = wr_w & (reg_addr_i == REG_MIN_REFERENCE_SPEED_CFG);
  wire wr_fv_w = wr_w & (reg_addr_i == REG_MAX_SPEED_VOLTAGE_CFG);
  wire wr_sv_w = wr_w & (reg_addr_i == REG_EXCITATION_START_VOLTAGE_CFG);
  wire wr_lv_w = wr_w & (reg_addr_i == REG_MIN_SPEED_VOLTAGE_CFG);
  wire wr_cv_w = wr_w & (reg_addr_i == REG_SLEEP_ENTRY_VOLTAGE_CFG);
  wire wr_st_w = wr_w & (reg_addr_i == REG_NVM_STORE);
  wire wr_mk_w = wr_w & (reg_addr_i == REG_FAULT_MASK);
  wire wr_fo_w = wr_w & (reg_addr_i == REG_FAULT_OUTPUT);
  wire wr_rn_w = wr_w & (reg_addr_i == REG_RUN);

  // Store request on a one-to-zero trigger edge; ignored while a store runs
  wire store_fall_w = wr_st_w & trigger_q & ~reg_wdata_i[STORE_BIT];
  wire store_go_w = store_fall_w & motor_stopped_i & unlocked_i
                    & (state_q == ST_IDLE);
  wire store_end_w = ce_i & (state_q == ST_STORE) & nvm_store_done_i;
  wire count_top_w = (count_q == {CNT_W{1'b1}});

  // Fault flags
  wire any_fault_w = (|fault_out_pin_q) | (|crit_q) | wear_q;
  wire [5:0] crit_flags_w = {any_fault_w, crit_q, wear_q};
  wire [4:0] fault_sel_w = {sel_hi_q, sel_lo_q};
  wire [4:0] gate_idx_w = fault_sel_w - SEL_GATE_FIRST;
  wire is_gate_w = (fault_sel_w >= SEL_GATE_FIRST) && (fault_sel_w <= SEL_GATE_LAST);
  wire gate_sel_w = pwm_gate_i[gate_idx_w[2:0]];
  logic sel_active_w;

  // Unlisted and reserved codes select nothing, so the pin stays high
  always_comb begin
    unique case (fault_sel_w)
      SEL_ANY_FAULT:   sel_active_w = any_fault_w;
      SEL_SYNC_DROP:   sel_active_w = fault_out_pin_q[F_SYNC_DROP];
      SEL_TIMEOUT:     sel_active_w = crit_q[1];
      SEL_POWER_STAGE: sel_active_w = fault_out_pin_q[F_POWER_STAGE];
      SEL_HARD_OC:     sel_active_w = fault_out_pin_q[F_HARD_OC];
      default:         sel_active_w = is_gate_w & gate_sel_w;
    endcase
  end

  // Read mux; unused bits zero
  logic [9:0] rd_low_w;
  always_comb begin
    unique case (reg_addr_i)
      REG_DEAD_TIME_CFG:           rd_low_w = {dtc_en_q, 1'b0, gain_q, ratio_q};
      REG_SPEED_LIMIT_CFG:         rd_low_w = {src_sel_q, 1'b0, user_tag_q, scale_q};
      REG_SPEED_REFERENCE_CFG:     rd_low_w = speed_code_q;
      REG_MIN_REFERENCE_SPEED_CFG: rd_low_w = min_code_q;
      REG_MAX_SPEED_VOLTAGE_CFG:   rd_low_w = full_volt_q;
      REG_EXCITATION_START_VOLTAGE_CFG: rd_low_w = start_volt_q;
      REG_MIN_SPEED_VOLTAGE_CFG:   rd_low_w = low_volt_q;
      REG_SLEEP_ENTRY_VOLTAGE_CFG: rd_low_w = sleep_volt_q;
      REG_NVM_STORE:               rd_low_w = count_q;
      REG_FAULT_MASK:              rd_low_w = {mask_q, 3'b000};
      REG_FAULT_OUTPUT:            rd_low_w = {fault_out_pin_q, 3'b000};
      REG_RUN:                     rd_low_w = {sel_lo_q, 8'h00};
      default:                     rd_low_w = 10'h000;
    endcase
  end

  // Derived frequencies in tenths of a hertz
  wire [4:0]  unit_w = {1'b0, scale_q} + 5'h01;
  wire [14:0] code_freq_w = speed_code_q * unit_w;
  wire [14:0] min_freq_w = min_code_q * unit_w;

  // Configuration registers
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dtc_en_q     <= RST_DTC_EN;
      gain_q       <= 4'h0;
      ratio_q      <= 4'h0;
      src_sel_q    <= RST_SRC_SEL;
      user_tag_q   <= 4'h0;
      scale_q      <= 4'h0;
      speed_code_q <= 10'h000;
      min_code_q   <= 10'h000;
      full_volt_q  <= RST_FULL_SPEED_VOLT;
      start_volt_q <= RST_START_EXCITE_VOLT;
      low_volt_q   <= RST_LOW_SPEED_VOLT;
      sleep_volt_q <= RST_SLEEP_ENTRY_VOLT;
      mask_q       <= 7'h00;
      sel_hi_q     <= 3'b000;
      sel_lo_q     <= 2'b00;
      trigger_q    <= 1'b0;
    end else begin
      if (wr_dt_w) begin
        dtc_en_q <= reg_wdata_i[DTC_EN_BIT];
        gain_q   <= reg_wdata_i[GAIN_LSB+:4];
        ratio_q  <= reg_wdata_i[RATIO_LSB+:4];
      end
      if (wr_sl_w) begin
        src_sel_q  <= reg_wdata_i[SRC_SEL_BIT];
        user_tag_q <= reg_wdata_i[TAG_LSB+:4];
        scale_q    <= reg_wdata_i[SCALE_LSB+:4];
      end
      if (wr_sr_w) speed_code_q <= reg_wdata_i[FIELD_W-1:0];
      if (wr_mn_w) min_code_q <= reg_wdata_i[FIELD_W-1:0];
      if (wr_fv_w) full_volt_q <= reg_wdata_i[FIELD_W-1:0];
      if (wr_sv_w) start_volt_q <= reg_wdata_i[FIELD_W-1:0];
      if (wr_lv_w) low_volt_q <= reg_wdata_i[FIELD_W-1:0];
      if (wr_cv_w) sleep_volt_q <= reg_wdata_i[FIELD_W-1:0];
      if (wr_st_w) trigger_q <= reg_wdata_i[STORE_BIT];
      if (wr_mk_w) mask_q <= reg_wdata_i[MASK_LSB+:NUM_MASKABLE];
      if (wr_fo_w) sel_hi_q <= reg_wdata_i[SEL_HI_LSB+:3];
      if (wr_rn_w) sel_lo_q <= reg_wdata_i[SEL_LO_LSB+:2];
    end
  end

  // Store sequence, write counter and wear flag
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q         <= ST_IDLE;
      nvm_store_req_o <= 1'b0;
      count_q         <= '0;
      wear_q          <= 1'b0;
    end else if (ce_i) begin
      unique case (state_q)
        ST_IDLE: if (store_go_w) begin
          state_q         <= ST_STORE;
          nvm_store_req_o <= 1'b1;
        end
        ST_STORE: if (store_end_w) begin
          state_q         <= ST_IDLE;
          nvm_store_req_o <= 1'b0;
          count_q         <= count_q + 1'b1;
          if (count_top_w) wear_q <= 1'b1;
        end
      endcase
    end
  end

  // Flags follow their sources; a mask bit blocks its flag outright
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fault_out_pin_q <= 7'h00;
      crit_q <= 4'h0;
    end else if (ce_i) begin
      fault_out_pin_q <= fault_raw_i & ~mask_q;
      crit_q <= {supply_undervolt_i, nvm_corrupt_i, timeout_fault_i, soft_overcurrent_i};
    end
  end

  // Registered outputs
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o           <= '0;
      fault_out_pin_o       <= 1'b1;
      dead_time_comp_en_o   <= RST_DTC_EN;
      dead_time_comp_gain_o <= 4'h0;
      dead_time_max_ratio_o <= 4'h0;
      speed_source_sel_o    <= RST_SRC_SEL;
      freq_step_o           <= 5'h01;
      ref_freq_o            <= '0;
      max_ref_freq_o        <= '0;
      min_ref_freq_o        <= '0;
      at_full_speed_o       <= 1'b0;
      excite_on_o           <= 1'b0;
      at_min_speed_o        <= 1'b0;
      sleep_mode_o          <= 1'b0;
    end else if (ce_i) begin
      if (reg_rd_i) reg_rdata_o <= {crit_flags_w, rd_low_w};
      fault_out_pin_o       <= ~sel_active_w;
      dead_time_comp_en_o   <= dtc_en_q;
      dead_time_comp_gain_o <= dtc_en_q ? gain_q : 4'h0;
      dead_time_max_ratio_o <= dtc_en_q ? ratio_q : 4'h0;
      speed_source_sel_o    <= src_sel_q;
      freq_step_o           <= unit_w;
      ref_freq_o            <= src_sel_q ? code_freq_w : 15'h0000;
      max_ref_freq_o        <= src_sel_q ? 15'h0000 : code_freq_w;
      min_ref_freq_o        <= min_freq_w;
      // Analog points only apply in external mode; the analog input is ignored otherwise
      at_full_speed_o <= ~src_sel_q & (speed_cmd_voltage_i >= full_volt_q);
      excite_on_o     <= ~src_sel_q & (speed_cmd_voltage_i >= start_volt_q);
      at_min_speed_o  <= ~src_sel_q & (speed_cmd_voltage_i <= low_volt_q);
      sleep_mode_o    <= ~src_sel_q & (speed_cmd_voltage_i <= sleep_volt_q);
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_store_start;
    ce_i && store_go_w;
  endsequence
  sequence s_store_finish;
    ce_i && (state_q == ST_STORE) && nvm_store_done_i;
  endsequence

  chk_store_request: assert property (s_store_start |=> nvm_store_req_o)
    else $error("store request not raised");
  chk_store_gate: assert property (ce_i && wr_st_w && !motor_stopped_i
                                   && state_q == ST_IDLE |=> !nvm_store_req_o)
    else $error("store started while motor runs");
  chk_count_step: assert property (s_store_finish |=> count_q == $past(count_q) + 1'b1
                                   && !nvm_store_req_o)
    else $error("write counter did not step");
  chk_wear_sticky: assert property (wear_q |=> wear_q)
    else $error("wear flag cleared");
  chk_wear_set: assert property (s_store_finish ##0 count_top_w |=> wear_q)
    else $error("wear flag not set at counter wrap");
  chk_mask_blocks: assert property (ce_i && mask_q[F_HARD_OC] |=> !fault_out_pin_q[F_HARD_OC])
    else $error("masked fault still flagged");
  chk_pin_any: assert property (ce_i && fault_sel_w == SEL_ANY_FAULT && any_fault_w
                                |=> !fault_out_pin_o)
    else $error("fault pin not low on general fault");
  chk_pin_reserved: assert property (ce_i && fault_sel_w >= 5'h18 |=> fault_out_pin_o)
    else $error("reserved select drove the pin");
  chk_read_flags: assert property (ce_i && reg_rd_i |=> reg_rdata_o[15:10]
                                   == $past(crit_flags_w))
    else $error("read lost critical flags");
  chk_gain_gate: assert property (ce_i && !dtc_en_q |=> dead_time_comp_gain_o == 4'h0)
    else $error("gain active while compensation off");
  chk_ref_freq: assert property (ce_i && src_sel_q |=> ref_freq_o
                                 == $past(speed_code_q) * $past(unit_w))
    else $error("reference frequency wrong");
  chk_ratio_gate: assert property (ce_i && !dtc_en_q |=>
                                   dead_time_max_ratio_o == 4'h0)
    else $error("ratio active while compensation off");
  chk_ext_ref_zero: assert property (ce_i && !src_sel_q |=>
                                     ref_freq_o == 15'h0000)
    else $error("internal reference leaked in external mode");
  chk_max_freq: assert property (ce_i && !src_sel_q |=> max_ref_freq_o
                                 == $past(speed_code_q) * $past(unit_w))
    else $error("maximum reference frequency wrong");
  chk_min_freq: assert property (ce_i |=> min_ref_freq_o
                                 == $past(min_code_q) * $past(unit_w))
    else $error("minimum reference frequency wrong");
  // Register mode must blind all four analog comparators
  chk_cmp_internal: assert property (ce_i && src_sel_q |=>
                                     !at_full_speed_o && !excite_on_o
                                     && !at_min_speed_o && !sleep_mode_o)
    else $error("analog point active in register mode");
  chk_pin_sync: assert property (ce_i && fault_sel_w == SEL_SYNC_DROP |=>
                                 fault_out_pin_o == !$past(fault_out_pin_q[F_SYNC_DROP]))
    else $error("sync drop not routed to pin");
  chk_pin_gate: assert property (ce_i && fault_sel_w == SEL_GATE_FIRST |=>
                                 fault_out_pin_o == !$past(pwm_gate_i[0]))
    else $error("gate drive not routed to pin");
  chk_store_hold: assert property (ce_i && state_q == ST_STORE
                                   && !nvm_store_done_i |=> nvm_store_req_o)
    else $error("store request dropped early");
  // Enable low must leave stored state alone, even with a write strobe present
  chk_ce_freeze: assert property (!ce_i |=> $stable(count_q)
                                  && $stable(speed_code_q))
    else $error("state moved while clock enable low");
endmodule : mcr_regs

`default_nettype wire

// >>> hdl/mcr_pkg.sv
// Package for the motor controller configuration and diagnostic register bank.
// Assumes the serial link front end presents decoded 5-bit register numbers.
package mcr_pkg;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned FIELD_W = 10;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned CODE_W = 10;
  localparam int unsigned NUM_MASKABLE = 7;
  localparam int unsigned NUM_GATES = 6;

  // Register numbers
  localparam logic [4:0] REG_DEAD_TIME_CFG = 5'h0e;
  localparam logic [4:0] REG_SPEED_LIMIT_CFG = 5'h0f;
  localparam logic [4:0] REG_SPEED_REFERENCE_CFG = 5'h10;
  localparam logic [4:0] REG_MIN_REFERENCE_SPEED_CFG = 5'h11;
  localparam logic [4:0] REG_MAX_SPEED_VOLTAGE_CFG = 5'h12;
  localparam logic [4:0] REG_EXCITATION_START_VOLTAGE_CFG = 5'h13;
  localparam logic [4:0] REG_MIN_SPEED_VOLTAGE_CFG = 5'h14;
  localparam logic [4:0] REG_SLEEP_ENTRY_VOLTAGE_CFG = 5'h15;
  localparam logic [4:0] REG_NVM_STORE = 5'h1c;
  localparam logic [4:0] REG_FAULT_MASK = 5'h1d;
  localparam logic [4:0] REG_FAULT_OUTPUT = 5'h1e;
  localparam logic [4:0] REG_RUN = 5'h1f;

  // Field positions
  localparam int unsigned DTC_EN_BIT = 9;
  localparam int unsigned GAIN_LSB = 4;
  localparam int unsigned RATIO_LSB = 0;
  localparam int unsigned SRC_SEL_BIT = 9;
  localparam int unsigned TAG_LSB = 4;
  localparam int unsigned SCALE_LSB = 0;
  localparam int unsigned STORE_BIT = 9;
  localparam int unsigned MASK_LSB = 3;
  localparam int unsigned SEL_HI_LSB = 2;
  localparam int unsigned SEL_LO_LSB = 8;

  // Reset values
  localparam logic [9:0] RST_FULL_SPEED_VOLT = 10'h366;
  localparam logic [9:0] RST_START_EXCITE_VOLT = 10'h1b3;
  localparam logic [9:0] RST_LOW_SPEED_VOLT = 10'h15c;
  localparam logic [9:0] RST_SLEEP_ENTRY_VOLT = 10'h0ae;
  localparam logic RST_DTC_EN = 1'b1;
  localparam logic RST_SRC_SEL = 1'b1;

  // Fault output select codes
  localparam logic [4:0] SEL_ANY_FAULT = 5'h00;
  localparam logic [4:0] SEL_SYNC_DROP = 5'h01;
  localparam logic [4:0] SEL_GATE_FIRST = 5'h09;
  localparam logic [4:0] SEL_GATE_LAST = 5'h0e;
  localparam logic [4:0] SEL_TIMEOUT = 5'h0f;
  localparam logic [4:0] SEL_POWER_STAGE = 5'h11;
  localparam logic [4:0] SEL_HARD_OC = 5'h13;

  // Maskable fault order, bit 6 down to bit 0
  localparam int unsigned F_HEAT_WARN = 6;
  localparam int unsigned F_HEAT_SHUT = 5;
  localparam int unsigned F_SYNC_DROP = 4;
  localparam int unsigned F_POWER_STAGE = 3;
  localparam int unsigned F_HARD_OC = 2;

  typedef enum logic [0:0] {ST_IDLE, ST_STORE} mcr_store_state_t;
endpackage : mcr_pkg

// >>> verification/mcr_nvm_model.sv
// NVM engine stand-in that answers store requests of the register bank.
// Assumes the bank's clock and a request level held until done is seen.
`timescale 1ns/1ps
`default_nettype none
module mcr_nvm_model (
  input  wire logic       clock_i,
  input  wire logic       req_i,
  input  wire logic [3:0] wait_i,
  output logic            done_o
);
  logic [3:0] cnt_q;
  // Done stands until the request drops, so no store is half seen
  always_ff @(posedge clock_i) begin
    if (!req_i) begin
      cnt_q  <= 4'h0;
      done_o <= 1'b0;
    end else if (cnt_q >= wait_i) begin
      done_o <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule : mcr_nvm_model
`default_nettype wire

// >>> verification/mcr_regs_test.sv
// Self-checking bench of the register bank against a behavioural model.
// Assumes one 200 MHz clock; inputs change on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module mcr_regs_test;
  import mcr_pkg::*;
  logic        clock_i = 0, reset_n_i = 0, ce_i = 1, reg_wr_i = 0, reg_rd_i = 0;
  logic [4:0]  reg_addr_i = 0;
  logic [15:0] reg_wdata_i = 0, reg_rdata_o, v;
  logic [6:0]  fault_raw_i = 0, f;
  logic        supply_undervolt_i = 0, nvm_corrupt_i = 0, timeout_fault_i = 0;
  logic        soft_overcurrent_i = 0, motor_stopped_i = 0, unlocked_i = 0;
  logic        nvm_store_done_i, nvm_store_req_o, fault_out_pin_o, wear = 0;
  logic [5:0]  pwm_gate_i = 0;
  logic [9:0]  speed_cmd_voltage_i = 0;
  logic        dead_time_comp_en_o, speed_source_sel_o, at_full_speed_o;
  logic        excite_on_o, at_min_speed_o, sleep_mode_o, p;
  logic [3:0]  dead_time_comp_gain_o, dead_time_max_ratio_o, wait_q = 0;
  logic [4:0]  freq_step_o, c;
  logic [14:0] ref_freq_o, max_ref_freq_o, min_ref_freq_o;
  logic [31:0] seed = 32'h37e7, r;
  logic [9:0]  m [32];
  int          err_count = 0, n_compared = 0, cyc = 0, i, cnt = 0;
  int          adr [12] = '{14, 15, 16, 17, 18, 19, 20, 21, 29, 31, 0, 26};
  int          sel [15] = '{0, 1, 9, 10, 11, 12, 13, 14, 15, 17, 19, 24, 31, 2, 16};

  mcr_regs dut (.clock_i, .reset_n_i, .ce_i, .reg_addr_i, .reg_wr_i, .reg_rd_i,
    .reg_wdata_i, .reg_rdata_o, .fault_raw_i, .supply_undervolt_i, .nvm_corrupt_i,
    .timeout_fault_i, .soft_overcurrent_i, .pwm_gate_i, .motor_stopped_i, .unlocked_i,
    .nvm_store_done_i, .speed_cmd_voltage_i, .nvm_store_req_o, .fault_out_pin_o,
    .dead_time_comp_en_o, .dead_time_comp_gain_o, .dead_time_max_ratio_o,
    .speed_source_sel_o, .freq_step_o, .ref_freq_o, .max_ref_freq_o, .min_ref_freq_o,
    .at_full_speed_o, .excite_on_o, .at_min_speed_o, .sleep_mode_o);
  mcr_nvm_model nvm (.clock_i, .req_i(nvm_store_req_o), .wait_i(wait_q),
    .done_o(nvm_store_done_i));

  always #2.5 clock_i = ~clock_i;
  // Ceiling well above the wear run of about 5100 cycles
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      results();
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // Writable bits; holes read zero
  function automatic logic [9:0] wm(input logic [4:0] a);
    case (a)
      14, 15: return 10'h2ff;
      29: return 10'h3f8;
      31: return 10'h300;
      default: return 10'h3ff;
    endcase
  endfunction : wm
  function automatic logic [15:0] er(input logic [4:0] a);
    if (a == 28) return {wear, 4'h0, wear, 10'(cnt)};
    if (a inside {[14:21], 29, 31}) return {wear, 4'h0, wear, m[a]};
    return {wear, 4'h0, wear, 10'h0};
  endfunction : er
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e) begin
      err_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge clock_i);
    reg_wr_i = 1'b0;
    if (a inside {[14:21], 29, 31}) m[a] = d[9:0] & wm(a);
    // Idle edge so a following access never re-raises the strobe in the same step
    @(negedge clock_i);
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge clock_i);
    reg_rd_i = 1'b0;
    d = reg_rdata_o;
    @(negedge clock_i);
  endtask : rd
  task automatic outs();
    logic [14:0] u;
    logic x;
    u = 15'(m[15][3:0]) + 15'd1;
    x = !m[15][9];
    chk(dead_time_comp_en_o, m[14][9]);
    chk(dead_time_comp_gain_o, m[14][9] ? m[14][7:4] : 4'h0);
    chk(dead_time_max_ratio_o, m[14][9] ? m[14][3:0] : 4'h0);
    chk(speed_source_sel_o, m[15][9]);
    chk(freq_step_o, u);
    chk(ref_freq_o, x ? 15'h0 : m[16] * u);
    chk(max_ref_freq_o, x ? m[16] * u : 15'h0);
    chk(min_ref_freq_o, m[17] * u);
    chk(at_full_speed_o, x && speed_cmd_voltage_i >= m[18]);
    chk(excite_on_o, x && speed_cmd_voltage_i >= m[19]);
    chk(at_min_speed_o, x && speed_cmd_voltage_i <= m[20]);
    chk(sleep_mode_o, x && speed_cmd_voltage_i <= m[21]);
  endtask : outs
  task automatic store(input logic go);
    int k;
    wr(5'h1c, 16'h0200);
    wr(5'h1c, 16'h0000);
    chk(nvm_store_req_o, go);
    for (k = 0; k < 40 && nvm_store_req_o === 1'b1; k++) @(negedge clock_i);
    if (go) begin
      wear = wear | (cnt == 1023);
      cnt = (cnt + 1) % 1024;
    end
  endtask : store
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results

  initial begin
    m = '{default: 10'h0};
    m[14] = {RST_DTC_EN, 9'h0};
    m[15] = {RST_SRC_SEL, 9'h0};
    m[18] = RST_FULL_SPEED_VOLT;
    m[19] = RST_START_EXCITE_VOLT;
    m[20] = RST_LOW_SPEED_VOLT;
    m[21] = RST_SLEEP_ENTRY_VOLT;
    repeat (6) @(negedge clock_i);
    reset_n_i = 1'b1;
    @(negedge clock_i);
    outs();
    chk(fault_out_pin_o, 1'b1);
    foreach (adr[k]) begin
      rd(5'(adr[k]), v);
      chk(v, er(5'(adr[k])));
    end
    $display("test reset values done");
    for (i = 0; i < 40; i++) begin
      r = rnd();
      c = 5'(adr[r[3:0] % 12]);
      speed_cmd_voltage_i = r[29:20];
      wr(c, r[31:16] ^ r[15:0]);
      rd(c, v);
      chk(v, er(c));
      @(negedge clock_i);
      outs();
    end
    $display("test settings done");
    foreach (sel[k]) begin
      r = rnd();
      c = 5'(sel[k]);
      wr(5'h1d, r[15:0]);
      fault_raw_i = r[22:16];
      {supply_undervolt_i, nvm_corrupt_i, timeout_fault_i, soft_overcurrent_i} = r[26:23];
      pwm_gate_i = r[31:26];
      wr(5'h1e, {11'h0, c[4:2], 2'b0});
      wr(5'h1f, {6'h0, c[1:0], 8'h0});
      repeat (3) @(negedge clock_i);
      f = fault_raw_i & ~m[29][9:3];
      p = 1'b1;
      if (c == 0) p = ~(|{f, supply_undervolt_i, nvm_corrupt_i, timeout_fault_i,
        soft_overcurrent_i, wear});
      if (c == 1) p = ~f[4];
      if (c inside {[9:14]}) p = ~pwm_gate_i[c - 9];
      if (c == 15) p = ~timeout_fault_i;
      if (c == 17) p = ~f[3];
      if (c == 19) p = ~f[2];
      chk(fault_out_pin_o, p);
      rd(5'h1e, v);
      chk(v, {(|f) | supply_undervolt_i | nvm_corrupt_i | timeout_fault_i
        | soft_overcurrent_i | wear, supply_undervolt_i, nvm_corrupt_i, timeout_fault_i,
        soft_overcurrent_i, wear, f, 3'b0});
    end
    {fault_raw_i, supply_undervolt_i, nvm_corrupt_i, timeout_fault_i} = 10'h0;
    soft_overcurrent_i = 1'b0;
    $display("test faults done");
    @(negedge clock_i);
    ce_i = 1'b0;
    reg_addr_i = 5'h10;
    reg_wdata_i = {6'h0, ~m[16]};
    reg_wr_i = 1'b1;
    @(negedge clock_i);
    reg_wr_i = 1'b0;
    ce_i = 1'b1;
    rd(5'h10, v);
    chk(v, er(5'h10));
    $display("test enable done");
    store(1'b0);
    motor_stopped_i = 1'b1;
    store(1'b0);
    unlocked_i = 1'b1;
    wait_q = 4'd9;
    store(1'b1);
    wait_q = 4'd0;
    store(1'b1);
    @(negedge clock_i);
    rd(5'h1c, v);
    chk(v, er(5'h1c));
    $display("test store done");
    for (i = 0; i < 1100 && !wear; i++) store(1'b1);
    store(1'b1);
    rd(5'h1c, v);
    chk(v, er(5'h1c));
    chk(v[10], 1'b1);
    $display("test wear done");
    results();
  end
endmodule : mcr_regs_test
`default_nettype wire
